// ### rtl/dsr_pkg.sv
package dsr_pkg;
  localparam int unsigned RES_W       = 15;
  localparam int unsigned BIT_IDX_W   = 4;
  localparam logic [3:0]  MSB_IDX     = 4'he;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  localparam logic [2:0]  NAP_PULSES  = 3'h2;
  localparam logic [2:0]  SLEEP_PULSES = 3'h4;
  localparam logic [2:0]  WAKE_PULSES = 3'h5;
  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned POR_WAIT_MS = 10;
  localparam int unsigned POR_CYCLES  = POR_WAIT_MS * 1000 * 1000 * CLK_MHZ
                                        / 1000;
  typedef enum logic [1:0] {
    DSR_OPER  = 2'b00,
    DSR_NAP   = 2'b01,
    DSR_SLEEP = 2'b10
  } dsr_pwr_t;
endpackage

// ### rtl/dsr_adc_readout.sv
`timescale 1ns/10ps
`default_nettype none
module dsr_adc_readout import dsr_pkg::*; #(
  parameter int unsigned POR_COUNT = POR_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             readout_clk,
  input  wire logic             conversion_strobe,
  input  wire logic             lvds_select,
  input  wire logic             echo_neg_strap,
  input  wire logic [RES_W-1:0] ch1_result,
  input  wire logic [RES_W-1:0] ch2_result,
  output logic                  sampler_track,
  output logic                  convert_start,
  output logic                  channel_one_serial_out,
  output logic                  channel_one_serial_out_n,
  output logic                  channel_two_serial_out,
  output logic                  channel_two_serial_out_n,
  output logic                  echo_readout_clock,
  output logic                  echo_readout_clock_n,
  output logic                  echo_neg_oe,
  output logic [1:0]            power_state,
  output logic                  ready
);

  // ----------------------------------------------------------------
  // Input synchronisers and strobe edges
  // ----------------------------------------------------------------
  logic [2:0] cnv_sync_r;
  logic [1:0] lvds_sync_r;
  logic [1:0] strap_sync_r;
  logic       cnv_rise;
  logic       cnv_fall;
  logic       lvds_r;
  logic       strap_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnv_sync_r   <= 3'h0;
      lvds_sync_r  <= 2'h0;
      strap_sync_r <= 2'h0;
    end else begin
      cnv_sync_r   <= {cnv_sync_r[1:0], conversion_strobe};
      lvds_sync_r  <= {lvds_sync_r[0], lvds_select};
      strap_sync_r <= {strap_sync_r[0], echo_neg_strap};
    end
  end

  assign cnv_rise = cnv_sync_r[1] & ~cnv_sync_r[2];
  assign cnv_fall = ~cnv_sync_r[1] & cnv_sync_r[2];
  assign lvds_r   = lvds_sync_r[1];
  assign strap_r  = strap_sync_r[1];

  // ----------------------------------------------------------------
  // Power-on wait
  // ----------------------------------------------------------------
  logic [31:0] por_cnt_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_r <= 32'h0;
    end else if (por_cnt_r != POR_COUNT) begin
      por_cnt_r <= por_cnt_r + 32'h1;
    end
  end

  assign ready = (por_cnt_r == POR_COUNT);

  // ----------------------------------------------------------------
  // Sample and conversion control
  // ----------------------------------------------------------------
  logic [RES_W-1:0] ch1_prev_r;
  logic [RES_W-1:0] ch2_prev_r;
  logic             load_tgl_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sampler_track <= 1'b0;
    end else if (cnv_rise) begin
      sampler_track <= 1'b1;
    end else if (cnv_fall) begin
      sampler_track <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      convert_start <= 1'b0;
    end else begin
      convert_start <= cnv_fall;
    end
  end

  // latch signed result on convert_start, loaded into the link shifter after ld_sync_r
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ch1_prev_r <= '0;
      ch2_prev_r <= '0;
      load_tgl_r <= 1'b0;
    end else if (convert_start) begin
      ch1_prev_r <= ch1_result;
      ch2_prev_r <= ch2_result;
      load_tgl_r <= ~load_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: serial shifting
  // ----------------------------------------------------------------
  logic [2:0]       ld_sync_r;
  logic [RES_W-1:0] sh1_r;
  logic [RES_W-1:0] sh2_r;
  logic [3:0]       bit_cnt_r;
  logic             sck_tgl_r;
  logic             link_rst_n_r;
  logic             link_rst_n_s;

  always_ff @(posedge readout_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_rst_n_s <= 1'b0;
      link_rst_n_r <= 1'b0;
    end else begin
      link_rst_n_s <= 1'b1;
      link_rst_n_r <= link_rst_n_s;
    end
  end

  always_ff @(negedge readout_clk or negedge arst_n) begin
    if (!arst_n) begin
      ld_sync_r <= 3'h0;
    end else begin
      ld_sync_r <= {ld_sync_r[1:0], load_tgl_r};
    end
  end

  always_ff @(negedge readout_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh1_r     <= '0;
      sh2_r     <= '0;
      bit_cnt_r <= CNT_ZERO;
    end else if (ld_sync_r[2] != ld_sync_r[1]) begin
      sh1_r     <= ch1_prev_r;
      sh2_r     <= ch2_prev_r;
      bit_cnt_r <= MSB_IDX;
    end else if (bit_cnt_r != CNT_ZERO) begin
      sh1_r     <= {sh1_r[RES_W-2:0], 1'b0};
      sh2_r     <= {sh2_r[RES_W-2:0], 1'b0};
      bit_cnt_r <= bit_cnt_r - CNT_ONE;
    end
  end

  // Activity toggle for wake detection
  always_ff @(posedge readout_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_tgl_r <= 1'b0;
    end else if (link_rst_n_r) begin
      sck_tgl_r <= ~sck_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  logic d1;
  logic d2;
  logic eck;
  assign d1  = sh1_r[RES_W-1];
  assign d2  = sh2_r[RES_W-1];
  assign eck = readout_clk & ~(strap_r & ~lvds_r);

  assign channel_one_serial_out   = d1;
  assign channel_two_serial_out   = d2;
  assign echo_readout_clock       = eck;
  assign channel_one_serial_out_n = lvds_r & ~d1;
  assign channel_two_serial_out_n = lvds_r & ~d2;
  assign echo_readout_clock_n     = lvds_r & ~readout_clk;
  assign echo_neg_oe              = lvds_r;

  // ----------------------------------------------------------------
  // Nap and sleep control
  // ----------------------------------------------------------------
  logic [2:0] act_sync_r;
  logic       sck_seen;
  logic [2:0] pulse_cnt_r;
  dsr_pwr_t   pwr_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      act_sync_r <= 3'h0;
    end else begin
      act_sync_r <= {act_sync_r[1:0], sck_tgl_r};
    end
  end

  assign sck_seen = act_sync_r[2] != act_sync_r[1];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r       <= DSR_OPER;
      pulse_cnt_r <= 3'h0;
    end else if (sck_seen) begin
      pulse_cnt_r <= 3'h0;
      if (pwr_r == DSR_NAP || !lvds_r) begin
        pwr_r <= DSR_OPER;
      end
    end else if (cnv_rise) begin
      case (pulse_cnt_r + 3'h1)
        NAP_PULSES: begin
          pwr_r       <= DSR_NAP;
          pulse_cnt_r <= pulse_cnt_r + 3'h1;
        end
        SLEEP_PULSES: begin
          pwr_r       <= DSR_SLEEP;
          pulse_cnt_r <= pulse_cnt_r + 3'h1;
        end
        WAKE_PULSES: begin
          pwr_r       <= DSR_OPER;
          pulse_cnt_r <= 3'h0;
        end
        default: begin
          pulse_cnt_r <= pulse_cnt_r + 3'h1;
        end
      endcase
    end
  end

  assign power_state = pwr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence two_rises_s;
    cnv_rise ##[1:1000] cnv_rise;
  endsequence

  track_on_rise_a: assert property (@(posedge clock) disable iff (!arst_n)
    cnv_rise |=> sampler_track) else $error("no tracking after rise");
  hold_on_fall_a: assert property (@(posedge clock) disable iff (!arst_n)
    cnv_fall |=> convert_start && !sampler_track)
    else $error("no convert after fall");
  nap_entry_a: assert property (@(posedge clock) disable iff (!arst_n)
    pwr_r == DSR_OPER && pulse_cnt_r == 3'h1 && cnv_rise && !sck_seen
    |=> pwr_r == DSR_NAP) else $error("nap not entered");
  nap_wake_a: assert property (@(posedge clock) disable iff (!arst_n)
    pwr_r == DSR_NAP && sck_seen |=> pwr_r == DSR_OPER)
    else $error("nap not left on clock");
  sleep_entry_a: assert property (@(posedge clock) disable iff (!arst_n)
    pwr_r == DSR_NAP && pulse_cnt_r == 3'h3 && cnv_rise && !sck_seen
    |=> pwr_r == DSR_SLEEP) else $error("sleep not entered");
  cmos_wake_a: assert property (@(posedge clock) disable iff (!arst_n)
    pwr_r == DSR_SLEEP && !lvds_r && sck_seen |=> pwr_r == DSR_OPER)
    else $error("cmos sleep wake failed");
  fifth_wake_a: assert property (@(posedge clock) disable iff (!arst_n)
    pwr_r == DSR_SLEEP && pulse_cnt_r == 3'h4 && cnv_rise && !sck_seen
    |=> pwr_r == DSR_OPER)
    else $error("fifth pulse wake failed");
  por_wait_a: assert property (@(posedge clock) disable iff (!arst_n)
    ready |=> ready) else $error("ready dropped");
  shift_msb_a: assert property (@(negedge readout_clk) disable iff (!arst_n)
    bit_cnt_r != CNT_ZERO && ld_sync_r[2] == ld_sync_r[1]
    |=> sh1_r[RES_W-1] == $past(sh1_r[RES_W-2]))
    else $error("shift order wrong");

  // ----------------------------------------------------------------
  // Further checks
  // ----------------------------------------------------------------
  sequence quiet_rise_s;
    cnv_rise && !sck_seen;
  endsequence

  conv_pulse_one_a: assert property (@(posedge clock)
    disable iff (!arst_n) convert_start |=> !convert_start)
    else $error("convert pulse too long");
  echo_off_a: assert property (@(posedge clock)
    disable iff (!arst_n) !lvds_r && strap_r |-> !echo_readout_clock)
    else $error("echo not disabled");
  cmos_legs_a: assert property (@(posedge clock)
    disable iff (!arst_n) !lvds_r |-> !channel_one_serial_out_n &&
    !channel_two_serial_out_n && !echo_readout_clock_n)
    else $error("negative leg driven in cmos");
  lvds_legs_a: assert property (@(posedge clock)
    disable iff (!arst_n) lvds_r |->
    channel_one_serial_out_n != channel_one_serial_out &&
    channel_two_serial_out_n != channel_two_serial_out)
    else $error("data pair not complementary");
  wake_restart_a: assert property (@(posedge clock)
    disable iff (!arst_n) pwr_r == DSR_SLEEP && pulse_cnt_r == 3'h4
    ##0 quiet_rise_s |=> pulse_cnt_r == 3'h0)
    else $error("pulse count not restarted");
  // clock clears count in lvds sleep
  lvds_sleep_a: assert property (@(posedge clock)
    disable iff (!arst_n) pwr_r == DSR_SLEEP && lvds_r && sck_seen
    |=> pwr_r == DSR_SLEEP && pulse_cnt_r == 3'h0)
    else $error("lvds sleep left on clock");
  oper_count_a: assert property (@(posedge clock)
    disable iff (!arst_n) pwr_r == DSR_OPER && pulse_cnt_r == 3'h0
    ##0 quiet_rise_s |=> pwr_r == DSR_OPER && pulse_cnt_r == 3'h1)
    else $error("first strobe miscounted");
  load_word_a: assert property (@(negedge readout_clk)
    disable iff (!arst_n) ld_sync_r[2] != ld_sync_r[1]
    |=> bit_cnt_r == MSB_IDX && sh1_r == $past(ch1_prev_r) &&
    sh2_r == $past(ch2_prev_r))
    else $error("result word not loaded");
  ready_late_a: assert property (@(posedge clock)
    disable iff (!arst_n) por_cnt_r != POR_COUNT |-> !ready)
    else $error("ready too early");

endmodule // dsr_adc_readout
`default_nettype wire

// ### tb/dsr_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// Controller side of the link
// ----------------------------
module dsr_ctrl_model import dsr_pkg::*; (
  input  wire logic clock,
  output logic      readout_clk,
  output logic      conversion_strobe,
  input  wire logic sampler_track,
  input  wire logic channel_one_serial_out,
  input  wire logic channel_two_serial_out,
  input  wire logic echo_readout_clock
);
  // Clock stands still low outside frames
  initial begin
    readout_clk = 1'b0;
    conversion_strobe = 1'b0;
  end

  task automatic strobe(output logic trk);
    @(posedge clock);
    conversion_strobe <= 1'b1;
    repeat (6) @(posedge clock);
    trk = sampler_track;
    repeat (4) @(posedge clock);
    conversion_strobe <= 1'b0;
    repeat (10) @(posedge clock);
  endtask

  // readout clock, fixed 6ns period here
  task automatic sck_pulse();
    #2.3;
    readout_clk = 1'b1;
    #3;
    readout_clk = 1'b0;
    #3;
  endtask

  task automatic read_word(output logic [RES_W-1:0] w1, output logic
    [RES_W-1:0] w2, output int echo_hi);
    echo_hi = 0;
    #2.3;
    for (int p = 1; p <= 18; p++) begin
      readout_clk = 1'b1;
      if (p >= 4) begin
        w1 = {w1[RES_W-2:0], channel_one_serial_out};
        w2 = {w2[RES_W-2:0], channel_two_serial_out};
      end
      #1;
      echo_hi += int'(echo_readout_clock);
      #2;
      readout_clk = 1'b0;
      #3;
    end
  endtask
endmodule // dsr_ctrl_model
`default_nettype wire

// ### tb/dsr_adc_readout_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  err_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module dsr_adc_readout_bench import dsr_pkg::*; ();
  logic             clock, arst_n, lvds_select, echo_neg_strap;
  logic             readout_clk, conversion_strobe, trk;
  logic [RES_W-1:0] ch1_result, ch2_result;
  logic             sampler_track, convert_start, ready, echo_neg_oe;
  logic             d1, d1_n, d2, d2_n, echo, echo_n;
  logic [1:0]       power_state;
  int               err_count, comparisons, cs_count, c0;

  dsr_adc_readout #(.POR_COUNT(20)) i_dut (.clock(clock), .arst_n(arst_n),
    .readout_clk(readout_clk), .conversion_strobe(conversion_strobe),
    .lvds_select(lvds_select), .echo_neg_strap(echo_neg_strap),
    .ch1_result(ch1_result), .ch2_result(ch2_result),
    .sampler_track(sampler_track), .convert_start(convert_start),
    .channel_one_serial_out(d1), .channel_one_serial_out_n(d1_n),
    .channel_two_serial_out(d2), .channel_two_serial_out_n(d2_n),
    .echo_readout_clock(echo), .echo_readout_clock_n(echo_n),
    .echo_neg_oe(echo_neg_oe), .power_state(power_state), .ready(ready));

  dsr_ctrl_model u_ctl (.clock(clock), .readout_clk(readout_clk),
    .conversion_strobe(conversion_strobe), .sampler_track(sampler_track),
    .channel_one_serial_out(d1), .channel_two_serial_out(d2),
    .echo_readout_clock(echo));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) if (convert_start === 1'b1) cs_count++;

  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run();
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_read(input logic lv, input logic st,
    input logic [RES_W-1:0] a);
    logic [RES_W-1:0] w1, w2;
    int eh;
    @(posedge clock);
    lvds_select <= lv;
    echo_neg_strap <= st;
    ch1_result <= a;
    ch2_result <= ~a;
    u_ctl.strobe(trk);
    u_ctl.read_word(w1, w2, eh);
    @(posedge clock);
    ch1_result <= a ^ 15'h1234;
    u_ctl.strobe(trk);
    u_ctl.read_word(w1, w2, eh);
    `CHK(w1, a ^ 15'h1234)
    `CHK(w2, ~a)
    `CHK(eh, (st && !lv) ? 0 : 18)
    `CHK(echo_neg_oe, lv)
    if (lv) `CHK({d1_n, d2_n, echo_n}, {~d1, ~d2, ~echo})
    else `CHK({d1_n, d2_n, echo_n}, 3'h0)
  endtask

  task automatic pchk(input int n, input logic [1:0] e);
    repeat (n) u_ctl.strobe(trk);
    `CHK(power_state, e)
  endtask

  task automatic wake(input logic [1:0] e);
    u_ctl.sck_pulse();
    repeat (8) @(posedge clock);
    `CHK(power_state, e)
  endtask

  initial begin
    arst_n = 1'b0;
    lvds_select = 1'b0;
    echo_neg_strap = 1'b0;
    ch1_result = 15'h0000;
    ch2_result = 15'h0000;
    repeat (2) @(posedge clock);
    `CHK(power_state, 2'h0)
    arst_n <= 1'b1;
    repeat (18) @(posedge clock);
    `CHK(ready, 1'b0)
    repeat (6) @(posedge clock);
    `CHK(ready, 1'b1)
    c0 = cs_count;
    u_ctl.strobe(trk);
    `CHK(trk, 1'b1)
    `CHK(cs_count - c0, 1)
    `CHK(sampler_track, 1'b0)
    t_read(1'b0, 1'b0, 15'h4a5c);
    t_read(1'b1, 1'b0, 15'h35a3);
    t_read(1'b0, 1'b1, 15'h7001);
    pchk(2, DSR_NAP);
    wake(DSR_OPER);
    pchk(2, DSR_NAP);
    pchk(2, DSR_SLEEP);
    wake(DSR_OPER);
    pchk(4, DSR_SLEEP);
    pchk(1, DSR_OPER);
    pchk(2, DSR_NAP);
    @(posedge clock);
    lvds_select <= 1'b1;
    wake(DSR_OPER);
    pchk(4, DSR_SLEEP);
    pchk(1, DSR_OPER);
    u_ctl.strobe(trk);
    wake(DSR_OPER);
    pchk(1, DSR_OPER);
    pchk(3, DSR_SLEEP);
    wake(DSR_SLEEP);
    complete_run();
  end
endmodule // dsr_adc_readout_bench
`default_nettype wire
